// *** lstmc_pkg.sv ***
// Constants shared by the strobe/torch mode controller and its helpers.
// Assumes a 10 MHz system clock and a 250 kHz internal oscillator rate.

package lstmc_pkg;

   // ==========================================================
   // Clock and oscillator rates
   localparam int unsigned SYS_CLK_KHZ  = 10000;
   localparam int unsigned OSC_CLK_KHZ  = 250;
   localparam int unsigned OSC_DIV      = SYS_CLK_KHZ / OSC_CLK_KHZ;
   localparam int unsigned DIV_W        = 6;

   // ==========================================================
   // Timing, in their own units, and derived oscillator counts
   localparam int unsigned SAFE_TIME_MS = 1000;
   localparam int unsigned GAIN_TIME_MS = 32;
   localparam int unsigned SAFE_TICKS   = SAFE_TIME_MS * OSC_CLK_KHZ;
   localparam int unsigned GAIN_TICKS   = GAIN_TIME_MS * OSC_CLK_KHZ;
   localparam int unsigned CNT_W        = 20;

   // ==========================================================
   // Reset values
   localparam logic        RST_OFF      = 1'h0;

   // ==========================================================
   // Operating modes
   typedef enum logic [1:0]
   {
      MODE_OFF,
      MODE_TORCH,
      MODE_STROBE
   } lstmc_mode_t;

endpackage

// *** lstmc_osc_tick.sv ***
// Internal oscillator tick: one-cycle pulse every OSC_DIV system clocks.
// Assumes one clock domain; runs only while the controller is enabled.

`timescale 1ns/1ps
`default_nettype none

module lstmc_osc_tick
(
   // Clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_b,
   // Control
   input  wire logic     run,
   // Tick
   output var  logic     tick_ff
);

   logic [lstmc_pkg::DIV_W-1:0] div_ff;

   // ==========================================================
   // Divider
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_ff  <= '0;
         tick_ff <= lstmc_pkg::RST_OFF;
      end
      else if (!run)
      begin
         div_ff  <= '0;
         tick_ff <= 1'h0;
      end
      else if (div_ff == lstmc_pkg::DIV_W'(lstmc_pkg::OSC_DIV - 1))
      begin
         div_ff  <= '0;
         tick_ff <= 1'h1;
      end
      else
      begin
         div_ff  <= div_ff + 1'h1;
         tick_ff <= 1'h0;
      end
   end

endmodule

`default_nettype wire

// *** lstmc_persist.sv ***
// Persistence counter: pulses once a condition has held for more than LIMIT ticks.
// Assumes tick is a one-cycle pulse; clr or a dropped condition restarts it.

`timescale 1ns/1ps
`default_nettype none

module lstmc_persist
#(
   parameter logic [lstmc_pkg::CNT_W-1:0] LIMIT = 20'h00010
)
(
   // Clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_b,
   // Control
   input  wire logic     clr,
   input  wire logic     cond,
   input  wire logic     tick,
   // Result
   output var  logic     hit_ff
);

   logic [lstmc_pkg::CNT_W-1:0] cnt_ff;

   // ==========================================================
   // Counter, held at LIMIT once reached
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= '0;
         hit_ff <= lstmc_pkg::RST_OFF;
      end
      else if (clr || !cond)
      begin
         cnt_ff <= '0;
         hit_ff <= 1'h0;
      end
      else if (tick)
      begin
         if (cnt_ff == LIMIT)
         begin
            hit_ff <= 1'h1;
         end
         else
         begin
            cnt_ff <= cnt_ff + 1'h1;
            hit_ff <= 1'h0;
         end
      end
      else
      begin
         hit_ff <= 1'h0;
      end
   end

endmodule

`default_nettype wire

// *** lstmc_ctrl.sv ***
// Strobe/torch mode and protection controller for a charge-pump LED driver.
// Assumes strobe_req, torch_en and guard indications are synchronous to sys_clk.

`timescale 1ns/1ps
`default_nettype none

module lstmc_ctrl
#(
   parameter logic [lstmc_pkg::CNT_W-1:0] SAFE_LIMIT = 20'(lstmc_pkg::SAFE_TICKS),
   parameter logic [lstmc_pkg::CNT_W-1:0] GAIN_LIMIT = 20'(lstmc_pkg::GAIN_TICKS)
)
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   // Host control inputs
   input  wire logic                 strobe_req,
   input  wire logic                 torch_en,
   // Analogue comparator indications
   input  wire logic                 input_overvoltage_guard,
   input  wire logic                 output_overvoltage_guard,
   input  wire logic                 over_temp_guard,
   input  wire logic                 short_circuit_guard,
   input  wire logic                 unity_reg_fail,
   // Mode and reference selection
   output var  lstmc_pkg::lstmc_mode_t mode_ff,
   output var  logic                 ref_250mv_ff,
   // Output stage control
   output var  logic                 led_en_ff,
   output var  logic                 pump_run_ff,
   output var  logic                 pump_2x_ff,
   output var  logic                 current_limited_ff,
   output var  logic                 overcurrent_guard_hi_ff,
   // Status
   output var  logic                 safety_timeout_ff
);

   lstmc_pkg::lstmc_mode_t nxt_mode;
   logic                   enabled;
   logic                   osc_tick;
   logic                   safe_hit;
   logic                   gain_hit;
   logic                   gain_2x_ff;
   logic                   nxt_gain_2x;
   logic                   nxt_timeout;
   logic                   nxt_pump_2x;
   logic                   device_block;

   // ==========================================================
   // Mode selection
   assign enabled = strobe_req || torch_en;

   always_comb
   begin
      if (strobe_req)
      begin
         nxt_mode = lstmc_pkg::MODE_STROBE;
      end
      else if (torch_en)
      begin
         nxt_mode = lstmc_pkg::MODE_TORCH;
      end
      else
      begin
         nxt_mode = lstmc_pkg::MODE_OFF;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_ff      <= lstmc_pkg::MODE_OFF;
         ref_250mv_ff <= lstmc_pkg::RST_OFF;
      end
      else
      begin
         mode_ff      <= nxt_mode;
         // 250mV in strobe, 100mV otherwise
         ref_250mv_ff <= (nxt_mode == lstmc_pkg::MODE_STROBE);
      end
   end

   // ==========================================================
   // Oscillator-based timers
   lstmc_osc_tick u_tick
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .run     (enabled),
      .tick_ff (osc_tick)
   );

   // Strobe held continuously beyond the safety limit
   lstmc_persist #(.LIMIT(SAFE_LIMIT)) u_safe
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clr     (!enabled),
      .cond    (strobe_req),
      .tick    (osc_tick),
      .hit_ff  (safe_hit)
   );

   // Unity-gain regulation failure persisting in torch mode
   lstmc_persist #(.LIMIT(GAIN_LIMIT)) u_gain
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clr     (!enabled),
      .cond    (torch_en && !strobe_req && !gain_2x_ff && unity_reg_fail),
      .tick    (osc_tick),
      .hit_ff  (gain_hit)
   );

   // ==========================================================
   // Safety timeout latch
   always_comb
   begin
      if (!strobe_req)
      begin
         nxt_timeout = 1'h0;
      end
      else if (safe_hit)
      begin
         nxt_timeout = 1'h1;
      end
      else
      begin
         nxt_timeout = safety_timeout_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         safety_timeout_ff <= lstmc_pkg::RST_OFF;
      end
      else
      begin
         safety_timeout_ff <= nxt_timeout;
      end
   end

   // ==========================================================
   // Torch pump gain latch
   always_comb
   begin
      if (!enabled)
      begin
         nxt_gain_2x = 1'h0;
      end
      else if (gain_hit)
      begin
         nxt_gain_2x = 1'h1;
      end
      else
      begin
         nxt_gain_2x = gain_2x_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gain_2x_ff <= lstmc_pkg::RST_OFF;
      end
      else
      begin
         gain_2x_ff <= nxt_gain_2x;
      end
   end

   // ==========================================================
   // Output stage and protection gating
   assign device_block = input_overvoltage_guard || over_temp_guard;
   assign nxt_pump_2x  = (nxt_mode == lstmc_pkg::MODE_STROBE) || nxt_gain_2x;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         led_en_ff               <= lstmc_pkg::RST_OFF;
         pump_run_ff             <= lstmc_pkg::RST_OFF;
         pump_2x_ff              <= lstmc_pkg::RST_OFF;
         current_limited_ff      <= lstmc_pkg::RST_OFF;
         overcurrent_guard_hi_ff <= lstmc_pkg::RST_OFF;
      end
      else
      begin
         // Guards gate the output only; mode and latches run on
         led_en_ff          <= (nxt_mode != lstmc_pkg::MODE_OFF) && !nxt_timeout
                               && !device_block;
         pump_run_ff        <= (nxt_mode != lstmc_pkg::MODE_OFF) && !nxt_timeout
                               && !device_block && !output_overvoltage_guard;
         pump_2x_ff         <= nxt_pump_2x;
         current_limited_ff <= short_circuit_guard;
         overcurrent_guard_hi_ff <= nxt_pump_2x;
      end
   end

   // ==========================================================
   // Checks
   chk_strobe_prio: assert property (@(posedge sys_clk) disable iff (!rst_b)
      strobe_req |=> mode_ff == lstmc_pkg::MODE_STROBE)
      else $error("strobe request did not select strobe mode");

   chk_torch_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (torch_en && !strobe_req) |=> mode_ff == lstmc_pkg::MODE_TORCH)
      else $error("torch enable did not select torch mode");

   chk_ref_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode_ff == lstmc_pkg::MODE_STROBE) |-> ref_250mv_ff)
      else $error("strobe mode without 250mV reference");

   chk_ref_torch: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode_ff == lstmc_pkg::MODE_TORCH) |-> !ref_250mv_ff)
      else $error("torch mode without 100mV reference");

   chk_safe_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (safe_hit && strobe_req) |=> (safety_timeout_ff && !led_en_ff))
      else $error("safety timeout did not disable output");

   chk_timeout_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (safety_timeout_ff && strobe_req) |=> (safety_timeout_ff || !$past(strobe_req)))
      else $error("timeout cleared while strobe stayed high");

   chk_timeout_rearm: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !strobe_req |=> !safety_timeout_ff)
      else $error("timeout not cleared by strobe low");

   chk_strobe_gain: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode_ff == lstmc_pkg::MODE_STROBE) |-> pump_2x_ff)
      else $error("strobe mode not in doubling gain");

   chk_torch_unity: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ((mode_ff == lstmc_pkg::MODE_TORCH) && ($past(mode_ff) == lstmc_pkg::MODE_OFF))
      |-> !pump_2x_ff)
      else $error("torch entry not in unity gain");

   chk_gain_switch: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (gain_hit && enabled) |=> (gain_2x_ff && pump_2x_ff))
      else $error("persistent unity failure did not select doubling");

   chk_gain_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (gain_2x_ff && enabled) |=> gain_2x_ff)
      else $error("doubling gain dropped while enabled");

   chk_device_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (input_overvoltage_guard || over_temp_guard) |=> (!led_en_ff && !pump_run_ff))
      else $error("guard did not disable device");

   chk_pump_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
      output_overvoltage_guard |=> !pump_run_ff)
      else $error("output overvoltage did not stop pump");

   chk_sc_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
      short_circuit_guard |=> current_limited_ff)
      else $error("short circuit did not limit current");

   chk_ocp_gain: assert property (@(posedge sys_clk) disable iff (!rst_b)
      overcurrent_guard_hi_ff == pump_2x_ff)
      else $error("current limit does not follow gain");

   chk_ocp_torch: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode_ff == lstmc_pkg::MODE_TORCH) |-> (overcurrent_guard_hi_ff == gain_2x_ff))
      else $error("torch current limit does not follow gain latch");

   chk_guard_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (device_block && safety_timeout_ff && strobe_req) |=> safety_timeout_ff)
      else $error("protection cleared the safety timeout");

   chk_off_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!strobe_req && !torch_en) |=> (!gain_2x_ff && !safety_timeout_ff && !safe_hit))
      else $error("off state did not clear timers and latch");

   chk_guard_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (device_block && strobe_req) |=> mode_ff == lstmc_pkg::MODE_STROBE)
      else $error("protection altered the mode");

endmodule

`default_nettype wire

// *** lstmc_host.sv ***
// Host model: camera controller driving the strobe request and torch enable.
// Assumes the bench sets want_* shortly after a clock edge.

`timescale 1ns/1ps
`default_nettype none

module lstmc_host
#(
   parameter int MAX_PULSE = 400
)
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Bench commands
   input  wire logic want_strobe,
   input  wire logic want_torch,
   input  wire logic allow_long,
   // Controller inputs
   output var  logic strobe_req,
   output var  logic torch_en
);
   int pulse_cnt;

   // Strobe pulse is cut short unless a long pulse is commanded
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pulse_cnt  <= 0;
         strobe_req <= 1'h0;
         torch_en   <= 1'h0;
      end
      else
      begin
         torch_en   <= want_torch;
         pulse_cnt  <= want_strobe ? pulse_cnt + 1 : 0;
         strobe_req <= want_strobe && (allow_long || pulse_cnt < MAX_PULSE);
      end
   end
endmodule

`default_nettype wire

// *** tb_lstmc_ctrl.sv ***
// Self-checking bench for the strobe/torch mode controller.
// Assumes shortened timer limits; one tick is 40 system clocks.

`timescale 1ns/1ps
`default_nettype none

module tb_lstmc_ctrl;
   typedef struct packed
   {
      logic s, t, iov, oov, ot, sc;
      lstmc_pkg::lstmc_mode_t mode;
      logic rf, led, run, x2, lim, hi;
   } lstmc_row_t;

   localparam logic H = 1'h1;
   localparam logic L = 1'h0;
   localparam lstmc_pkg::lstmc_mode_t MO = lstmc_pkg::MODE_OFF;
   localparam lstmc_pkg::lstmc_mode_t MT = lstmc_pkg::MODE_TORCH;
   localparam lstmc_pkg::lstmc_mode_t MS = lstmc_pkg::MODE_STROBE;
   localparam lstmc_row_t ROWS [8] = '{
      '{L,L,L,L,L,L, MO, L,L,L,L,L,L},
      '{H,L,L,L,L,L, MS, H,H,H,H,L,H},
      '{H,H,L,L,L,L, MS, H,H,H,H,L,H},
      '{L,H,L,L,L,L, MT, L,H,H,L,L,L},
      '{L,H,H,L,L,L, MT, L,L,L,L,L,L},
      '{H,L,L,H,L,L, MS, H,H,L,H,L,H},
      '{H,L,L,L,H,L, MS, H,L,L,H,L,H},
      '{L,H,L,L,L,H, MT, L,H,H,L,H,L}};

   // ==========================================================
   // Signals
   logic sys_clk, rst_b, want_strobe, want_torch, allow_long;
   logic strobe_req, torch_en, iov, oov, ot, sc, unity_reg_fail;
   lstmc_pkg::lstmc_mode_t mode_ff;
   logic ref_250mv_ff, led_en_ff, pump_run_ff, pump_2x_ff;
   logic current_limited_ff, overcurrent_guard_hi_ff, safety_timeout_ff;
   int   fail_count, tests_run, cycles;

   lstmc_host #(.MAX_PULSE(400)) lstmc_host_inst
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .want_strobe(want_strobe),
      .want_torch(want_torch), .allow_long(allow_long),
      .strobe_req(strobe_req), .torch_en(torch_en)
   );

   lstmc_ctrl #(.SAFE_LIMIT(20'h00014), .GAIN_LIMIT(20'h00005)) lstmc_ctrl_inst
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .strobe_req(strobe_req), .torch_en(torch_en),
      .input_overvoltage_guard(iov), .output_overvoltage_guard(oov),
      .over_temp_guard(ot), .short_circuit_guard(sc), .unity_reg_fail(unity_reg_fail),
      .mode_ff(mode_ff), .ref_250mv_ff(ref_250mv_ff), .led_en_ff(led_en_ff),
      .pump_run_ff(pump_run_ff), .pump_2x_ff(pump_2x_ff),
      .current_limited_ff(current_limited_ff),
      .overcurrent_guard_hi_ff(overcurrent_guard_hi_ff),
      .safety_timeout_ff(safety_timeout_ff)
   );

   // ==========================================================
   // Clock, timeout and reporting
   initial
   begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fail_count++;
         results();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      lstmc_row_t r;
      int n;
      fail_count = 0; tests_run = 0;
      rst_b = 1'h0; want_strobe = 1'h1; want_torch = 1'h0; allow_long = 1'h0;
      iov = 1'h0; oov = 1'h0; ot = 1'h0; sc = 1'h0; unity_reg_fail = 1'h0;
      wait_cyc(3);
      check("reset_mode", 8'(mode_ff), 8'(MO));
      check("reset_led", 8'(led_en_ff), 8'h00);
      rst_b = 1'h1;
      for (int i = 0; i < 8; i++)
      begin
         r = ROWS[i];
         want_strobe = r.s; want_torch = r.t;
         iov = r.iov; oov = r.oov; ot = r.ot; sc = r.sc;
         wait_cyc(3);
         check("mode", 8'(mode_ff), 8'(r.mode));
         check("ref", 8'(ref_250mv_ff), 8'(r.rf));
         check("led_en", 8'(led_en_ff), 8'(r.led));
         check("pump_run", 8'(pump_run_ff), 8'(r.run));
         check("pump_2x", 8'(pump_2x_ff), 8'(r.x2));
         check("cur_lim", 8'(current_limited_ff), 8'(r.lim));
         check("ocp_hi", 8'(overcurrent_guard_hi_ff), 8'(r.hi));
      end
      // Safety timeout on a held strobe, then re-arm
      want_strobe = 1'h0; want_torch = 1'h0; iov = 1'h0; oov = 1'h0; ot = 1'h0; sc = 1'h0;
      wait_cyc(3);
      allow_long = 1'h1; want_strobe = 1'h1; n = 0;
      while (safety_timeout_ff !== 1'h1 && n < 2000)
      begin
         wait_cyc(1);
         n++;
         if (n == 780) check("led_early", 8'(led_en_ff), 8'h01);
      end
      check("t_timeout", 8'(n >= 790 && n <= 880), 8'h01);
      wait_cyc(1);
      check("led_timeout", 8'(led_en_ff), 8'h00);
      check("mode_timeout", 8'(mode_ff), 8'(MS));
      want_torch = 1'h1;
      wait_cyc(3);
      check("led_held", 8'(led_en_ff), 8'h00);
      ot = 1'h1;
      wait_cyc(2);
      check("timeout_guard", 8'(safety_timeout_ff), 8'h01);
      check("mode_guard", 8'(mode_ff), 8'(MS));
      ot = 1'h0; want_strobe = 1'h0;
      wait_cyc(3);
      check("timeout_clr", 8'(safety_timeout_ff), 8'h00);
      check("torch_after", 8'(led_en_ff), 8'h01);
      want_strobe = 1'h1;
      wait_cyc(3);
      check("rearm_led", 8'(led_en_ff), 8'h01);
      // Gain persistence with a dropped failure, then latch until off
      want_strobe = 1'h0; want_torch = 1'h0; allow_long = 1'h0;
      wait_cyc(3);
      // Host cuts a strobe held past its pulse limit
      want_strobe = 1'h1;
      wait_cyc(410);
      check("host_cut", 8'(strobe_req), 8'h00);
      check("cut_led", 8'(led_en_ff), 8'h00);
      check("cut_timeout", 8'(safety_timeout_ff), 8'h00);
      want_strobe = 1'h0;
      wait_cyc(3);
      want_torch = 1'h1; unity_reg_fail = 1'h1;
      wait_cyc(150);
      unity_reg_fail = 1'h0;
      wait_cyc(3);
      unity_reg_fail = 1'h1; n = 0;
      while (pump_2x_ff !== 1'h1 && n < 600)
      begin
         wait_cyc(1);
         n++;
         if (n == 190) check("gain_early", 8'(pump_2x_ff), 8'h00);
      end
      check("t_gain", 8'(n >= 195 && n <= 300), 8'h01);
      unity_reg_fail = 1'h0;
      wait_cyc(50);
      check("gain_kept", 8'(pump_2x_ff), 8'h01);
      check("ocp_2x", 8'(overcurrent_guard_hi_ff), 8'h01);
      want_torch = 1'h0;
      wait_cyc(3);
      check("gain_off", 8'(pump_2x_ff), 8'h00);
      want_torch = 1'h1;
      wait_cyc(3);
      check("gain_reenter", 8'(pump_2x_ff), 8'h00);
      // Reset in mid-run, then strobe after release
      want_strobe = 1'h1;
      wait_cyc(3);
      rst_b = 1'h0;
      wait_cyc(1);
      check("rst_mode", 8'(mode_ff), 8'(MO));
      check("rst_led", 8'(led_en_ff), 8'h00);
      rst_b = 1'h1;
      wait_cyc(3);
      check("rel_mode", 8'(mode_ff), 8'(MS));
      check("rel_led", 8'(led_en_ff), 8'h01);
      check("rel_2x", 8'(pump_2x_ff), 8'h01);
      results();
   end
endmodule

`default_nettype wire
